// File: design/pfr_fault_ctrl.sv
`timescale 1ns/1ps
`include "pfr_defs.svh"
module pfr_fault_ctrl #(
	parameter int unsigned TICK_CYCLES = `PFR_TICK_CYCLES
) (
	input  wire logic                   core_clk_i,
	input  wire logic                   nrst_i,
	input  wire logic                   scl_i,
	input  wire logic                   sda_i,
	output logic                        sda_o,
	output logic                        sda_oe_o,
	input  wire logic [2:0]             address_strap_pins_i,
	input  wire logic [`PFR_NFAULT-1:0] fault_det_i,
	input  wire logic                   clear_faults_i,
	input  wire logic                   operation_on_i,
	output logic                        pol_enable_out_o,
	output logic                        fault_alert_n_o,
	output logic                        reference_dac_ramp_o,
	output logic                        peak_save_req_o,
	output logic [6:0]                  slave_address_o,
	output logic [`PFR_NFAULT-1:0]      fault_status_o
);
	localparam pfr_pkg::pfr_state_s RST = '{
		scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
		sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
		cfg: `PFR_CFG_RST, retry: `PFR_RETRY_RST,
		alert_n: 1'b1, st: pfr_pkg::PFR_IDLE, ack_to: pfr_pkg::PFR_IDLE,
		default: '0
	};

	pfr_pkg::pfr_state_s s;
	pfr_pkg::pfr_state_s n;
	logic                   tick;
	logic [`PFR_NFAULT-1:0] latch_hit;
	logic [`PFR_NFAULT-1:0] retry_hit;
	logic [`PFR_NFAULT-1:0] save_hit;

	pfr_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.core_clk_i(core_clk_i),
		.nrst_i    (nrst_i),
		.tick_o    (tick)
	);

	// per-fault action decode
	genvar i;
	generate
		for (i = 0; i < `PFR_NFAULT; i++) begin : g_act
			pfr_pkg::pfr_act_e act;
			assign act          = pfr_pkg::pfr_act_e'(s.cfg[2*i+1:2*i]);
			assign latch_hit[i] = fault_det_i[i] && act == pfr_pkg::PFR_ACT_LATCH;
			assign retry_hit[i] = fault_det_i[i] && act == pfr_pkg::PFR_ACT_RETRY;
			assign save_hit[i]  = fault_det_i[i] && act != pfr_pkg::PFR_ACT_REPORT;
		end
	endgenerate

	always_comb begin
		logic        scl_rise;
		logic        scl_fall;
		logic        start_c;
		logic        stop_c;
		logic [15:0] rd_word;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start_c  = 1'b0;
		stop_c   = 1'b0;
		rd_word  = 16'h0000;
		n        = s;
		n.peak   = 1'b0;

		// pin synchronisers
		n.scl_m   = scl_i;
		n.scl_s   = s.scl_m;
		n.scl_d   = s.scl_s;
		n.sda_m   = sda_i;
		n.sda_s   = s.sda_m;
		n.sda_d   = s.sda_s;
		n.strap_m = address_strap_pins_i;
		n.strap_s = s.strap_m;
		scl_rise  = s.scl_s && !s.scl_d;
		scl_fall  = !s.scl_s && s.scl_d;
		start_c   = s.scl_s && s.scl_d && s.sda_d && !s.sda_s;
		stop_c    = s.scl_s && s.scl_d && !s.sda_d && s.sda_s;

		// strap capture after reset release
		if (s.boot != 2'h3) begin
			n.boot = s.boot + 2'h1;
		end
		if (s.boot == 2'h2) begin
			n.addr = `PFR_ADDR_BASE | {4'h0, s.strap_s};
		end

		// read-back word
		case (s.cmd)
			`PFR_CMD_STATUS: begin
				rd_word[`PFR_ST_OV]    = s.status[0];
				rd_word[`PFR_ST_UV]    = s.status[1];
				rd_word[`PFR_ST_OC]    = s.status[2];
				rd_word[`PFR_ST_OT]    = s.status[3];
				rd_word[`PFR_ST_NC]    = s.status[4];
				rd_word[`PFR_ST_TEMP]  = s.status[3];
				rd_word[`PFR_ST_OTHER] = s.status[1] | s.status[4];
			end
			`PFR_CMD_CFG:   rd_word = s.cfg;
			`PFR_CMD_RETRY: rd_word = s.retry;
			`PFR_CMD_ADDR:  rd_word = {9'h000, s.addr};
			default:        rd_word = 16'h0000;
		endcase

		// bus slave
		if (start_c) begin
			n.st     = pfr_pkg::PFR_ADDR;
			n.bcnt   = 4'h0;
			n.nbytes = 2'h0;
		end else if (stop_c) begin
			if (s.nbytes == 2'h2) begin
				case (s.cmd)
					`PFR_CMD_CFG:   n.cfg = {s.whi, s.wlo} & `PFR_CFG_WMASK;
					`PFR_CMD_RETRY: n.retry = {s.whi, s.wlo};
					`PFR_CMD_ADDR: begin
						if (s.boot == 2'h3) begin
							n.addr = s.wlo[6:0];
						end
					end
					default: ;
				endcase
			end
			n.st     = pfr_pkg::PFR_IDLE;
			n.nbytes = 2'h0;
		end else begin
			unique case (s.st)
				pfr_pkg::PFR_IDLE: ;
				pfr_pkg::PFR_ADDR, pfr_pkg::PFR_CMD, pfr_pkg::PFR_WDATA: begin
					if (scl_rise && s.bcnt != 4'h8) begin
						n.sh   = {s.sh[6:0], s.sda_s};
						n.bcnt = s.bcnt + 4'h1;
					end else if (scl_fall && s.bcnt == 4'h8) begin
						n.bcnt = 4'h0;
						n.st   = pfr_pkg::PFR_ACK;
						if (s.st == pfr_pkg::PFR_ADDR) begin
							if (s.sh[7:1] != s.addr) begin
								n.st = pfr_pkg::PFR_IDLE;
							end else if (s.sh[0]) begin
								n.ack_to = pfr_pkg::PFR_RDATA;
								n.tx     = rd_word[7:0];
								n.rd_hi  = 1'b0;
							end else begin
								n.ack_to = pfr_pkg::PFR_CMD;
							end
						end else if (s.st == pfr_pkg::PFR_CMD) begin
							n.cmd    = s.sh;
							n.ack_to = pfr_pkg::PFR_WDATA;
						end else begin
							n.ack_to = pfr_pkg::PFR_WDATA;
							if (s.nbytes == 2'h0) begin
								n.wlo    = s.sh;
								n.nbytes = 2'h1;
							end else if (s.nbytes == 2'h1) begin
								n.whi    = s.sh;
								n.nbytes = 2'h2;
							end else begin
								n.st     = pfr_pkg::PFR_IDLE;
								n.nbytes = 2'h3;
							end
						end
					end
				end
				pfr_pkg::PFR_ACK: begin
					if (scl_fall) begin
						n.st = s.ack_to;
					end
				end
				pfr_pkg::PFR_RDATA: begin
					if (scl_fall) begin
						if (s.bcnt == 4'h7) begin
							n.st       = pfr_pkg::PFR_RACK;
							n.bcnt     = 4'h0;
							n.host_ack = 1'b0;
						end else begin
							n.tx   = {s.tx[6:0], 1'b0};
							n.bcnt = s.bcnt + 4'h1;
						end
					end
				end
				pfr_pkg::PFR_RACK: begin
					if (scl_rise) begin
						n.host_ack = !s.sda_s;
					end else if (scl_fall) begin
						if (s.host_ack && !s.rd_hi) begin
							n.tx    = rd_word[15:8];
							n.rd_hi = 1'b1;
							n.st    = pfr_pkg::PFR_RDATA;
						end else begin
							n.st = pfr_pkg::PFR_IDLE;
						end
					end
				end
			endcase
		end
		n.sda_oe = (n.st == pfr_pkg::PFR_ACK) || (n.st == pfr_pkg::PFR_RDATA && !n.tx[7]);

		// fault response
		n.op_d = operation_on_i;
		if (operation_on_i != s.op_d) begin
			n.pol_off = 1'b0;
			n.pend    = 1'b0;
		end
		if (tick && s.pend) begin
			if (s.rcnt == 16'h0000) begin
				n.pol_off = 1'b0;
				n.pend    = 1'b0;
			end else begin
				n.rcnt = s.rcnt - 16'h0001;
			end
		end
		if (|retry_hit) begin
			n.pol_off = 1'b1;
			n.pend    = 1'b1;
			n.rcnt    = s.retry;
		end
		if (|latch_hit) begin
			n.pol_off = 1'b1;
			n.pend    = 1'b0;
		end
		if (clear_faults_i) begin
			n.status = '0;
		end
		n.status  = n.status | fault_det_i;
		n.alert_n = ~|n.status;
		n.peak    = s.cfg[`PFR_CFG_PEAK] && |save_hit;
		n.en      = operation_on_i && !n.pol_off;
		n.ramp    = n.pol_off;
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= RST;
		end else begin
			s <= n;
		end
	end

	assign sda_o                = 1'b0;
	assign sda_oe_o             = s.sda_oe;
	assign pol_enable_out_o     = s.en;
	assign fault_alert_n_o      = s.alert_n;
	assign reference_dac_ramp_o = s.ramp;
	assign peak_save_req_o      = s.peak;
	assign slave_address_o      = s.addr;
	assign fault_status_o       = s.status;
endmodule

// File: pkg/pfr_defs.svh
`ifndef PFR_DEFS_SVH
`define PFR_DEFS_SVH

`define PFR_CMD_STATUS 8'hd8
`define PFR_CMD_CFG    8'hd9
`define PFR_CMD_RETRY  8'hda
`define PFR_CMD_ADDR   8'hdb

`define PFR_CFG_RST    16'h0000
`define PFR_RETRY_RST  16'h0000
`define PFR_CFG_WMASK  16'h83ff
`define PFR_CFG_PEAK   15
`define PFR_NFAULT     5

`define PFR_ST_OV      5
`define PFR_ST_UV      9
`define PFR_ST_OC      4
`define PFR_ST_OT      13
`define PFR_ST_NC      11
`define PFR_ST_TEMP    2
`define PFR_ST_OTHER   0

`define PFR_ADDR_BASE  7'h40

`define PFR_TICK_US     100
`define PFR_CLK_MHZ     100
`define PFR_TICK_CYCLES (`PFR_TICK_US * `PFR_CLK_MHZ)
`define PFR_TICK_W      14
`endif

// File: pkg/pfr_pkg.sv
`include "pfr_defs.svh"
package pfr_pkg;
	typedef enum logic [1:0] {
		PFR_ACT_REPORT = 2'h0,
		PFR_ACT_LATCH  = 2'h1,
		PFR_ACT_RETRY  = 2'h2,
		PFR_ACT_STORE  = 2'h3
	} pfr_act_e;

	typedef enum logic [2:0] {
		PFR_IDLE  = 3'h0,
		PFR_ADDR  = 3'h1,
		PFR_CMD   = 3'h2,
		PFR_WDATA = 3'h3,
		PFR_ACK   = 3'h4,
		PFR_RDATA = 3'h5,
		PFR_RACK  = 3'h6
	} pfr_bus_st_e;

	typedef struct packed {
		logic [`PFR_TICK_W-1:0] cnt;
		logic                   tick;
	} pfr_tick_s;

	typedef struct packed {
		logic                   scl_m;
		logic                   scl_s;
		logic                   scl_d;
		logic                   sda_m;
		logic                   sda_s;
		logic                   sda_d;
		logic [2:0]             strap_m;
		logic [2:0]             strap_s;
		logic [1:0]             boot;
		logic [6:0]             addr;
		pfr_bus_st_e            st;
		pfr_bus_st_e            ack_to;
		logic [3:0]             bcnt;
		logic [7:0]             sh;
		logic [7:0]             cmd;
		logic [1:0]             nbytes;
		logic [7:0]             wlo;
		logic [7:0]             whi;
		logic [7:0]             tx;
		logic                   rd_hi;
		logic                   host_ack;
		logic                   sda_oe;
		logic [15:0]            cfg;
		logic [15:0]            retry;
		logic [`PFR_NFAULT-1:0] status;
		logic                   alert_n;
		logic                   pol_off;
		logic                   pend;
		logic [15:0]            rcnt;
		logic                   op_d;
		logic                   en;
		logic                   ramp;
		logic                   peak;
	} pfr_state_s;
endpackage

// File: design/pfr_tick.sv
`timescale 1ns/1ps
`include "pfr_defs.svh"
module pfr_tick #(
	parameter int unsigned TICK_CYCLES = `PFR_TICK_CYCLES
) (
	input  wire logic core_clk_i,
	input  wire logic nrst_i,
	output logic      tick_o
);
	pfr_pkg::pfr_tick_s s;
	pfr_pkg::pfr_tick_s n;

	// free-running 100us tick
	always_comb begin
		n = s;
		n.tick = 1'b0;
		if (s.cnt == `PFR_TICK_W'(TICK_CYCLES - 1)) begin
			n.cnt  = '0;
			n.tick = 1'b1;
		end else begin
			n.cnt = s.cnt + `PFR_TICK_W'(1);
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tick_o = s.tick;
endmodule

// File: dv/pfr_fault_ctrl_assertions.sv
`timescale 1ns/1ps
module pfr_ck (
	input wire logic       core_clk_i,
	input wire logic       nrst_i,
	input wire logic [4:0] fault_det_i,
	input wire logic       operation_on_i,
	input wire logic       pol_enable_out_o,
	input wire logic       fault_alert_n_o,
	input wire logic       reference_dac_ramp_o,
	input wire logic       peak_save_req_o,
	input wire logic [4:0] fault_status_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);
	property p_al; |fault_det_i |=> !fault_alert_n_o; endproperty
	a_al: assert property (p_al) else $error("alert missing");
	property p_st;
		|fault_det_i |=> (fault_status_o & $past(fault_det_i)) == $past(fault_det_i);
	endproperty
	a_st: assert property (p_st) else $error("status missing");
	property p_fa; $fell(fault_alert_n_o) |-> $past(|fault_det_i); endproperty
	a_fa: assert property (p_fa) else $error("alert without fault");
	property p_an; fault_alert_n_o == (fault_status_o == 5'h0); endproperty
	a_an: assert property (p_an) else $error("alert vs status");
	property p_rp; reference_dac_ramp_o |-> !pol_enable_out_o; endproperty
	a_rp: assert property (p_rp) else $error("ramp while on");
	property p_dr; $fell(pol_enable_out_o) && $past(operation_on_i) |-> $past(|fault_det_i); endproperty
	a_dr: assert property (p_dr) else $error("drop without fault");
	property p_pk; peak_save_req_o |-> $past(|fault_det_i); endproperty
	a_pk: assert property (p_pk) else $error("peak without fault");
	property p_up; $rose(pol_enable_out_o) |-> $past(operation_on_i); endproperty
	a_up: assert property (p_up) else $error("enable without on");
	c_dr: cover property ($fell(pol_enable_out_o));
	c_pk: cover property (peak_save_req_o);
	c_up: cover property ($rose(pol_enable_out_o) && !fault_alert_n_o);
endmodule
bind pfr_fault_ctrl pfr_ck pfr_ck_i (
	.core_clk_i, .nrst_i, .fault_det_i, .operation_on_i, .pol_enable_out_o,
	.fault_alert_n_o, .reference_dac_ramp_o, .peak_save_req_o, .fault_status_o
);

// File: dv/pfr_h.sv
`timescale 1ns/1ps
module pfr_h (
	output logic      scl_o,
	output logic      sda_o,
	input  wire logic sda_i
);
	logic nak = 1'b0;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic bt(input logic b, output logic r);
		#41 sda_o = b;
		#41 scl_o = 1'b1;
		#43 r = sda_i;
		scl_o = 1'b0;
	endtask
	task automatic by(input logic [7:0] d, input logic a, output logic [7:0] q);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bt(d[i], q[i]);
		end
		bt(a, r);
		nak |= r & a;
	endtask
	task automatic go();
		nak = 1'b0;
		#62 sda_o = 1'b0;
		#62 scl_o = 1'b0;
	endtask
	task automatic sp();
		#41 sda_o = 1'b0;
		#41 scl_o = 1'b1;
		#62 sda_o = 1'b1;
		#62;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w);
		logic [7:0] q;
		go();
		by({a, 1'b0}, 1'b1, q);
		by(c, 1'b1, q);
		by(w[7:0], 1'b1, q);
		by(w[15:8], 1'b1, q);
		sp();
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [15:0] w);
		logic s;
		go();
		by({a, 1'b0}, 1'b1, w[7:0]);
		by(c, 1'b1, w[7:0]);
		#82 scl_o = 1'b1;
		go();
		by({a, 1'b1}, 1'b1, w[7:0]);
		by(8'hff, 1'b0, w[7:0]);
		s = nak;
		by(8'hff, 1'b1, w[15:8]);
		nak = s;
		sp();
	endtask
endmodule

// File: dv/pol_fault_response_retry_test.sv
`timescale 1ns/1ps
module pol_fault_response_retry_test;
	localparam int TK = 20;
	logic       clk, nrst, scl, hsda, so, oe, clr, op, en, aln, ramp, pk;
	logic [4:0] fd;
	logic [4:0] st;
	logic [6:0] adr;
	logic [2:0] strap;
	int         err_total;
	int         checked;
	wire        sda = hsda & !(oe & !so);
	pfr_fault_ctrl #(.TICK_CYCLES(TK)) pfr_fault_ctrl_i (
		.core_clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda), .sda_o(so),
		.sda_oe_o(oe), .address_strap_pins_i(strap), .fault_det_i(fd),
		.clear_faults_i(clr), .operation_on_i(op), .pol_enable_out_o(en),
		.fault_alert_n_o(aln), .reference_dac_ramp_o(ramp), .peak_save_req_o(pk),
		.slave_address_o(adr), .fault_status_o(st)
	);
	pfr_h pfr_h_i (.scl_o(scl), .sda_o(hsda), .sda_i(sda));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic ck(input string n, input logic [15:0] s, e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic cy(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic fresh();
		cy(1);
		op = 1'b0;
		clr = 1'b1;
		cy(2);
		op = 1'b1;
		clr = 1'b0;
		cy(3);
	endtask
	task automatic hit(input int k, output logic p);
		fd[k] = 1'b1;
		cy(1);
		fd = '0;
		p = pk;
		cy(1);
		p |= pk;
	endtask
	task automatic t_reset();
		logic [15:0] w;
		ck("adr", adr, 7'h45);
		pfr_h_i.rd(7'h45, 8'hd9, w);
		ck("cfg", w, 16'h0000);
		pfr_h_i.rd(7'h45, 8'hda, w);
		ck("rty", w, 16'h0000);
		$display("reset end");
	endtask
	task automatic t_codes();
		logic [15:0] w;
		logic p;
		pfr_h_i.wr(7'h45, 8'hd9, 16'hffff);
		pfr_h_i.rd(7'h45, 8'hd9, w);
		ck("mask", w, 16'h83ff);
		pfr_h_i.wr(7'h45, 8'hda, 16'h0064);
		for (int k = 0; k < 5; k++) begin
			for (int j = 0; j < 4; j++) begin
				pfr_h_i.wr(7'h45, 8'hd9, 16'h8000 | j << 2 * k);
				fresh();
				ck("on", en, 1);
				ck("clr", aln, 1'b1);
				hit(k, p);
				ck("st", st, 1 << k);
				ck("al", aln, 0);
				ck("pk", p, j != 0);
				ck("en", en, j == 0 || j == 3);
				ck("rmp", ramp, j == 1 || j == 2);
				cy(30);
				ck("off", en, j == 0 || j == 3);
			end
		end
		$display("codes end");
	endtask
	task automatic t_retry();
		logic [15:0] w;
		logic p;
		int n;
		pfr_h_i.wr(7'h45, 8'hd9, 16'h02aa);
		for (int j = 0; j < 2; j++) begin
			pfr_h_i.wr(7'h45, 8'hda, 3 * j);
			fresh();
			hit(3 * j, p);
			ck("nopk", p, 0);
			for (n = 2; en !== 1'b1 && n < 200; n++) begin
				cy(1);
			end
			if (n == 200) begin
				err_total++;
				complete_run();
			end
			ck("late", n >= 3 * j * TK, 1);
			ck("soon", n <= (3 * j + 1) * TK + 4, 1);
		end
		pfr_h_i.rd(7'h45, 8'hd8, w);
		ck("sts", w, 16'h2004);
		$display("retry end");
	endtask
	task automatic t_addr();
		logic [15:0] w;
		pfr_h_i.wr(7'h45, 8'hdb, 16'h0033);
		cy(5);
		ck("adr", adr, 7'h33);
		pfr_h_i.rd(7'h33, 8'hda, w);
		ck("rd", w, 16'h0003);
		pfr_h_i.wr(7'h45, 8'hda, 16'h0000);
		ck("nak", pfr_h_i.nak, 1'b1);
		$display("addr end");
	endtask
	task automatic t_reboot();
		logic [15:0] w;
		cy(1);
		clr = 1'b1;
		fd  = 5'h02;
		cy(1);
		clr = 1'b0;
		fd  = '0;
		ck("setwin", st, 5'h02);
		nrst  = 1'b0;
		strap = 3'h2;
		cy(4);
		nrst = 1'b1;
		cy(8);
		ck("adr2", adr, 7'h42);
		pfr_h_i.rd(7'h42, 8'hd9, w);
		ck("cfg2", w, 16'h0000);
		pfr_h_i.rd(7'h42, 8'hda, w);
		ck("rty2", w, 16'h0000);
		$display("reboot end");
	endtask
	initial begin
		err_total = 0;
		checked = 0;
		nrst = 1'b0;
		strap = 3'h5;
		fd = '0;
		clr = 1'b0;
		op = 1'b1;
		cy(4);
		nrst = 1'b1;
		cy(8);
		t_reset();
		t_codes();
		t_retry();
		t_addr();
		t_reboot();
		complete_run();
	end
endmodule
